// [logic/video_line_sampler_stats.sv]
// Video line readback: single or averaged line, then ROI min, max and mean
// Assumes pixels arrive from the chain after per-pixel correction
// Functional notes
// R1: Single-line command streams one raw line
// R2: Single line followed by ROI min/max/mean
// R3: Host keeps start index within 1..resolution
// R4: Host keeps end index above start
// R5: End index not above start becomes start
// R6: All values reported as 12-bit numbers
// R7: Sample count accepts 256/512/1024, default 1024
// R8: Sample count sets lines accumulated
// R9: Averaged command outputs per-pixel line averages
// R10: Averaged line followed by ROI statistics
// R11: Averaged data taken after gains and offsets
// R12: The same coefficient stages feed single-line samples
// R13: Sample count readable by dump and query; the code gives it on line_count_o and by query, not in the dump
// R14: Host checks range before calibrating
// R15: Mean truncates; capture starts at line start
`timescale 1ns/1ps

module sampler_fifo
#(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] fill_q;
   logic push;
   logic pop;

   assign in_ready_o = fill_q != (AW+1)'(DEPTH);
   assign out_valid_o = fill_q != '0;
   assign out_data_o = mem[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         fill_q <= '0;
      end
      else
      begin
         wr_q <= wr_q + AW'(push);
         rd_q <= rd_q + AW'(pop);
         fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module video_line_sampler_stats
   import video_sampler_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Pixel stream, taken after gains, offsets and background subtraction
   input wire logic [PIX_W-1:0] pixel_i,
   input wire logic pixel_valid_i,
   input wire logic line_valid_i,
   // Commands
   input wire cmd_s cmd_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   // Readback words
   output word_s out_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   // Status
   output logic [CNT_W-1:0] line_count_o,
   output logic busy_o
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_WAIT = 6'b000010,
      S_CAPTURE = 6'b000100,
      S_DUMP = 6'b001000,
      S_DIVIDE = 6'b010000,
      S_EMIT = 6'b100000
   } state_e;

   state_e state_q;
   logic [ACC_W-1:0] acc_mem [RES];
   logic [IDX_W-1:0] start_q;
   logic [IDX_W-1:0] end_q;
   logic avg_q;
   logic [CNT_W-1:0] lines_q;
   logic [CNT_W-1:0] target_q;
   logic [CNT_W-1:0] done_q;
   logic [IDX_W-1:0] col_q;
   logic [IDX_W-1:0] len_q;
   logic [IDX_W-1:0] idx_q;
   logic lv_q;
   logic [PIX_W-1:0] min_q;
   logic [PIX_W-1:0] max_q;
   logic [SUM_W-1:0] sum_q;
   logic [IDX_W-1:0] n_q;
   logic [REM_W-1:0] rem_q;
   logic [4:0] div_cnt_q;
   logic [1:0] stat_q;
   logic cmd_take;
   logic line_start;
   logic line_end;
   logic cap_en;
   logic [ACC_W-1:0] rd_word;
   logic [ACC_W-1:0] scaled;
   logic [PIX_W-1:0] pix_val;
   logic [IDX_W-1:0] pix_num;
   logic in_roi;
   logic [REM_W-1:0] rem_sh;
   logic rem_ge;
   logic [PIX_W-1:0] mean;
   word_s push_data;
   logic push_valid;
   logic push_ready;

   assign cmd_ready_o = (state_q == S_IDLE) & push_ready;
   assign cmd_take = cmd_valid_i & cmd_ready_o;
   assign busy_o = state_q != S_IDLE;
   assign line_count_o = lines_q; // R13
   assign line_start = line_valid_i & ~lv_q;
   assign line_end = ~line_valid_i & lv_q;
   // Only a line seen from its first pixel is captured
   assign cap_en = pixel_valid_i & line_valid_i & (col_q < IDX_W'(RES)) &
      ((state_q == S_CAPTURE) | ((state_q == S_WAIT) & line_start)); // R15
   assign rd_word = acc_mem[idx_q[IDX_W-2:0]];
   // Average is a shift since the line count is a power of two
   assign scaled = !avg_q ? rd_word :
      lines_q[10] ? (rd_word >> 10) :
      lines_q[9] ? (rd_word >> 9) : (rd_word >> 8); // R9
   assign pix_val = scaled[PIX_W-1:0]; // R6
   assign pix_num = idx_q + 13'h0001;
   assign in_roi = (pix_num >= start_q) & (pix_num <= end_q);
   assign rem_sh = {rem_q[REM_W-2:0], sum_q[SUM_W-1]};
   assign rem_ge = rem_sh >= {1'b0, n_q};
   assign mean = (n_q == '0) ? '0 : sum_q[PIX_W-1:0]; // R15

   always_comb
   begin
      push_valid = 1'b0;
      push_data = '{tag: TAG_PIXEL, value: pix_val};
      unique case (state_q)
         S_IDLE:
         begin
            push_valid = cmd_valid_i & (cmd_i.op == OP_GET_COUNT);
            push_data = '{tag: TAG_COUNT, value: PIX_W'(lines_q)}; // R13
         end
         S_DUMP:
         begin
            push_valid = 1'b1; // R1
         end
         S_EMIT:
         begin
            push_valid = 1'b1;
            unique case (stat_q)
               2'h0: push_data = '{tag: TAG_MIN, value: min_q};
               2'h1: push_data = '{tag: TAG_MAX, value: max_q};
               default: push_data = '{tag: TAG_MEAN, value: mean};
            endcase
         end
         default:
         begin
            push_valid = 1'b0;
         end
      endcase
   end

   sampler_fifo #(.WIDTH($bits(word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_data_i(push_data),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .out_data_o(out_o),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i)
   );

   // Sample count setting; illegal values are ignored
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         lines_q <= LINES_RST; // R7
      end
      else if (cmd_take & (cmd_i.op == OP_SET_COUNT) &
               ((cmd_i.count == LINES_256) | (cmd_i.count == LINES_512) |
                (cmd_i.count == LINES_1024)))
      begin
         lines_q <= cmd_i.count; // R7
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         start_q <= '0;
         end_q <= '0;
         avg_q <= 1'b0;
         target_q <= '0;
      end
      else if (cmd_take & ((cmd_i.op == OP_SINGLE) | (cmd_i.op == OP_AVG)))
      begin
         start_q <= cmd_i.start_idx;
         end_q <= (cmd_i.end_idx <= cmd_i.start_idx) ?
            cmd_i.start_idx : cmd_i.end_idx; // R5
         avg_q <= cmd_i.op == OP_AVG;
         target_q <= (cmd_i.op == OP_AVG) ? lines_q : 11'h001; // R8
      end
   end

   // First line overwrites, later lines add, so no clearing pass is needed
   always_ff @(posedge ref_clk_i)
   begin
      if (cap_en)
      begin
         acc_mem[col_q[IDX_W-2:0]] <= ((done_q == '0) ? '0 :
            acc_mem[col_q[IDX_W-2:0]]) + ACC_W'(pixel_i); // R9 R11 R12
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         lv_q <= 1'b0;
         col_q <= '0;
         len_q <= '0;
         done_q <= '0;
      end
      else
      begin
         lv_q <= line_valid_i;
         if (state_q == S_IDLE)
         begin
            done_q <= '0;
            col_q <= '0;
         end
         else if (state_q == S_CAPTURE & line_end)
         begin
            done_q <= done_q + 11'h001; // R8
            len_q <= col_q;
            col_q <= '0;
         end
         else if (cap_en)
         begin
            col_q <= col_q + 13'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_q <= S_IDLE;
         idx_q <= '0;
         div_cnt_q <= '0;
         stat_q <= '0;
      end
      else
      begin
         unique case (state_q)
            S_IDLE:
            begin
               if (cmd_take & ((cmd_i.op == OP_SINGLE) |
                               (cmd_i.op == OP_AVG)))
               begin
                  state_q <= S_WAIT;
               end
            end
            S_WAIT:
            begin
               if (line_start)
               begin
                  state_q <= S_CAPTURE; // R15
               end
            end
            S_CAPTURE:
            begin
               idx_q <= '0;
               // An empty line skips the dump, so the divider starts here too
               div_cnt_q <= '0;
               if (line_end & (done_q + 11'h001 == target_q))
               begin
                  state_q <= (col_q == '0) ? S_DIVIDE : S_DUMP;
               end
            end
            S_DUMP:
            begin
               div_cnt_q <= '0;
               if (push_ready)
               begin
                  idx_q <= idx_q + 13'h0001;
                  if (pix_num == len_q)
                  begin
                     state_q <= S_DIVIDE;
                  end
               end
            end
            S_DIVIDE:
            begin
               stat_q <= '0;
               div_cnt_q <= div_cnt_q + 5'h01;
               if (div_cnt_q == 5'(SUM_W - 1))
               begin
                  state_q <= S_EMIT;
               end
            end
            S_EMIT:
            begin
               if (push_ready)
               begin
                  stat_q <= stat_q + 2'h1;
                  if (stat_q == 2'h2)
                  begin
                     state_q <= S_IDLE; // R2 R10
                  end
               end
            end
            default:
            begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ROI statistics, then restoring division of the sum in place
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i | (state_q == S_WAIT))
      begin
         min_q <= MIN_RST;
         max_q <= MAX_RST;
         sum_q <= '0;
         n_q <= '0;
         rem_q <= '0;
      end
      else if (state_q == S_DUMP & push_ready & in_roi)
      begin
         min_q <= (pix_val < min_q) ? pix_val : min_q; // R2 R10
         max_q <= (pix_val > max_q) ? pix_val : max_q; // R2 R10
         sum_q <= sum_q + SUM_W'(pix_val);
         n_q <= n_q + 13'h0001;
      end
      else if (state_q == S_DIVIDE)
      begin
         rem_q <= rem_ge ? (rem_sh - {1'b0, n_q}) : rem_sh;
         sum_q <= {sum_q[SUM_W-2:0], rem_ge}; // R15
      end
   end

   a_end_not_below: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q != S_IDLE |-> end_q >= start_q) // R5
      else $error("end index below start index");
   a_count_legal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      lines_q == LINES_256 || lines_q == LINES_512 || lines_q == LINES_1024)
      else $error("illegal line sample count"); // R7
   a_count_default: assert property (@(posedge ref_clk_i)
      $fell(rst_i) |-> lines_q == LINES_1024) // R7
      else $error("sample count not at default after reset");
   a_count_query: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cmd_take && cmd_i.op == OP_GET_COUNT |-> push_valid &&
      push_data.tag == TAG_COUNT && push_data.value == line_count_o) // R13
      else $error("count query not answered");
   a_capture_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == S_CAPTURE) |-> $past(line_valid_i) && !$past(lv_q))
      else $error("capture began mid line"); // R15
   a_avg_lines: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(state_q == S_DUMP) |-> done_q == target_q &&
      target_q == (avg_q ? lines_q : 11'h001)) // R8
      else $error("wrong number of lines accumulated");
   a_stats_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_DUMP && push_ready && pix_num == len_q |=>
      ##[25:26] state_q == S_EMIT) // R2
      else $error("statistics not started after pixels");
   a_min_max: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_EMIT && n_q != '0 |-> min_q <= max_q) // R10
      else $error("ROI minimum above maximum");
   a_mean_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      push_valid && push_data.tag == TAG_MEAN && n_q != '0 |->
      push_data.value >= min_q && push_data.value <= max_q) // R15
      else $error("mean outside ROI range");
   a_single_raw: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_DUMP && !avg_q |-> rd_word == ACC_W'(pix_val)) // R1
      else $error("single line value altered");

   c_single_done: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_EMIT && !avg_q && stat_q == 2'h2 && push_ready);
   c_avg_done: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_EMIT && avg_q && stat_q == 2'h2 && push_ready);
   c_count_set: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      cmd_take && cmd_i.op == OP_SET_COUNT && cmd_i.count == LINES_256);
   c_fifo_full: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == S_DUMP && !push_ready);
endmodule

// [include/video_sampler_pkg.sv]
// Package for the video line sampler: sizes, settings, command and word types
// Assumes one pixel clock domain for the sampler and its output FIFO
package video_sampler_pkg;
   localparam int PIX_W = 12;
   localparam int RES = 4096;
   localparam int IDX_W = 13;
   localparam int CNT_W = 11;
   localparam int ACC_W = 22;
   localparam int SUM_W = 25;
   localparam int REM_W = 14;
   localparam int FIFO_DEPTH = 16;
   localparam logic [CNT_W-1:0] LINES_256 = 11'h100;
   localparam logic [CNT_W-1:0] LINES_512 = 11'h200;
   localparam logic [CNT_W-1:0] LINES_1024 = 11'h400;
   localparam logic [CNT_W-1:0] LINES_RST = LINES_1024;
   localparam logic [PIX_W-1:0] MIN_RST = 12'hfff;
   localparam logic [PIX_W-1:0] MAX_RST = 12'h000;

   typedef enum logic [1:0] {
      OP_SINGLE = 2'h0,
      OP_AVG = 2'h1,
      OP_SET_COUNT = 2'h2,
      OP_GET_COUNT = 2'h3
   } op_e;

   typedef struct packed {
      op_e op;
      logic [IDX_W-1:0] start_idx;
      logic [IDX_W-1:0] end_idx;
      logic [CNT_W-1:0] count;
   } cmd_s;

   typedef enum logic [2:0] {
      TAG_PIXEL = 3'h0,
      TAG_MIN = 3'h1,
      TAG_MAX = 3'h2,
      TAG_MEAN = 3'h3,
      TAG_COUNT = 3'h4
   } tag_e;

   typedef struct packed {
      tag_e tag;
      logic [PIX_W-1:0] value;
   } word_s;
endpackage

// [verification/host_model.sv]
// Host model: issues sampler commands and drains readback words
// Assumes one clock; drives just after the falling edge
`timescale 1ns/1ps

module host_model
   import video_sampler_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Commands
   output cmd_s cmd_o,
   output logic cmd_valid_o,
   input wire logic cmd_ready_i,
   // Readback
   input wire word_s out_i,
   input wire logic out_valid_i,
   output logic out_ready_o
);
   word_s got[$];
   logic hold = 1'b0;

   initial
   begin
      cmd_o = '0;
      cmd_valid_o = 1'b0;
      out_ready_o = 1'b1;
   end

   // Random stalls, or a long hold, push the output FIFO to full
   always @(negedge ref_clk_i)
      out_ready_o <= !hold && ($urandom % 3 != 0);

   always @(posedge ref_clk_i)
      if (out_valid_i && out_ready_o)
         got.push_back(out_i);

   // Command and valid stay put until the edge that takes them
   task automatic send(input cmd_s c);
      int n;
      n = 0;
      @(negedge ref_clk_i);
      cmd_o = c;
      cmd_valid_o = 1'b1;
      do
         @(posedge ref_clk_i);
      while (!cmd_ready_i && ++n < 20000);
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b0;
      // Released lines show no stale command
      cmd_o = ~c;
   endtask
endmodule

// [verification/video_line_sampler_stats_tb.sv]
// Testbench for the video line sampler with its host model
// Assumes a 100 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps

module video_line_sampler_stats_tb;
   import video_sampler_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [PIX_W-1:0] pixel_i = '0;
   logic pixel_valid_i = 1'b0;
   logic line_valid_i = 1'b0;
   cmd_s cmd_i;
   logic cmd_valid_i;
   logic cmd_ready_o;
   word_s out_o;
   logic out_valid_o;
   logic out_ready_i;
   logic [CNT_W-1:0] line_count_o;
   logic busy_o;
   int bad_count = 0;
   int total_checks = 0;
   int unsigned acc[64];

   always #5 ref_clk_i = ~ref_clk_i;

   video_line_sampler_stats i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .pixel_i(pixel_i), .pixel_valid_i(pixel_valid_i),
      .line_valid_i(line_valid_i), .cmd_i(cmd_i),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .out_o(out_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
      .line_count_o(line_count_o), .busy_o(busy_o));

   host_model i_host (.ref_clk_i(ref_clk_i), .cmd_o(cmd_i),
      .cmd_valid_o(cmd_valid_i), .cmd_ready_i(cmd_ready_o),
      .out_i(out_o), .out_valid_i(out_valid_o), .out_ready_o(out_ready_i));

   task automatic print_verdict;
      $display("Checks %0d, errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input word_s g, input word_s e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR at %0t: word %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_cnt(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR at %0t: value %h expected %h", $time, g, e);
      end
   endtask

   function automatic word_s mkw(input tag_e t, input int unsigned v);
      mkw.tag = t;
      mkw.value = v[PIX_W-1:0];
   endfunction

   function automatic cmd_s mkc(input op_e o, input int s, input int e,
      input logic [CNT_W-1:0] c);
      mkc = '{o, s[IDX_W-1:0], e[IDX_W-1:0], c};
   endfunction

   // Waits for n words, bounded, then compares them in order
   task automatic take(input word_s ex[$]);
      int w;
      w = 0;
      while (i_host.got.size() < ex.size() && w++ < 20000)
         @(posedge ref_clk_i);
      chk_cnt(CNT_W'(i_host.got.size()), CNT_W'(ex.size()));
      foreach (ex[k])
         chk(i_host.got[k], ex[k]);
      i_host.got.delete();
      @(negedge ref_clk_i);
   endtask

   // Gaps with pixel valid low inside the line must not count
   task automatic drive_line(input int n);
      int unsigned r;
      for (int k = 0; k < n; k++)
      begin
         @(negedge ref_clk_i);
         if (k > 0 && $urandom % 4 == 0)
         begin
            pixel_valid_i = 1'b0;
            pixel_i = ~pixel_i;
            @(negedge ref_clk_i);
         end
         r = $urandom;
         line_valid_i = 1'b1;
         pixel_valid_i = 1'b1;
         pixel_i = r[PIX_W-1:0];
         acc[k] += pixel_i;
      end
      @(negedge ref_clk_i);
      line_valid_i = 1'b0;
      pixel_valid_i = 1'b0;
      pixel_i = ~pixel_i;
      @(negedge ref_clk_i);
   endtask

   task automatic run(input op_e o, input int n, input int s, input int e,
      input int lines);
      word_s ex[$];
      int unsigned v, mn, mx, sum, cnt;
      foreach (acc[k])
         acc[k] = 0;
      i_host.send(mkc(o, s, e, '0));
      chk_cnt(CNT_W'(busy_o), 11'h001);
      for (int j = 0; j < lines; j++)
         drive_line(n);
      repeat (30) @(negedge ref_clk_i);
      // A held drain keeps a long line from finishing
      if (i_host.hold)
         chk_cnt(CNT_W'(busy_o), 11'h001);
      i_host.hold = 1'b0;
      if (e <= s)
         e = s;
      mn = 'hfff;
      mx = 0;
      sum = 0;
      cnt = 0;
      for (int k = 1; k <= n; k++)
      begin
         v = acc[k-1] >> $clog2(lines);
         ex.push_back(mkw(TAG_PIXEL, v));
         if (k >= s && k <= e)
         begin
            mn = (v < mn) ? v : mn;
            mx = (v > mx) ? v : mx;
            sum += v;
            cnt++;
         end
      end
      ex.push_back(mkw(TAG_MIN, mn));
      ex.push_back(mkw(TAG_MAX, mx));
      ex.push_back(mkw(TAG_MEAN, cnt ? sum / cnt : 0));
      take(ex);
   endtask

   task automatic get_count(input logic [CNT_W-1:0] c);
      word_s ex[$];
      i_host.send(mkc(OP_GET_COUNT, 1, 2, '0));
      ex.push_back(mkw(TAG_COUNT, c));
      take(ex);
   endtask

   initial
   begin
      #700000;
      bad_count++;
      print_verdict();
   end

   initial
   begin
      logic [CNT_W-1:0] vals[4];
      logic [CNT_W-1:0] cur;
      int seed, n, s, e;
      seed = $urandom(32'hbf93);
      vals = '{11'h12c, LINES_512, LINES_1024, LINES_256};
      cur = LINES_RST;
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk_cnt(line_count_o, LINES_1024);
      get_count(LINES_1024);
      // The first value is outside the accepted set and must be ignored
      foreach (vals[i])
      begin
         i_host.send(mkc(OP_SET_COUNT, 1, 2, vals[i]));
         if (vals[i] inside {LINES_256, LINES_512, LINES_1024})
            cur = vals[i];
         chk_cnt(line_count_o, cur);
         get_count(cur);
      end
      // Readback before any calibration, corner cases first
      for (int t = 0; t < 5; t++)
      begin
         n = 1 + $urandom % 40;
         if (t == 0)
            n = 40;
         s = 1 + $urandom % n;
         e = s + 1 + $urandom % 8;
         if (t == 1)
            e = s - ($urandom % 2);
         if (t == 2)
            s = n + 1;
         i_host.hold = (t == 0);
         run(OP_SINGLE, n, s, e, 1);
      end
      foreach (vals[i])
      begin
         // Every legal count, so each shift of the average is used
         if (i < 1)
            continue;
         i_host.send(mkc(OP_SET_COUNT, 1, 2, vals[i]));
         n = 2 + $urandom % 7;
         s = 1 + $urandom % (n - 1);
         e = s + 1 + $urandom % 4;
         run(OP_AVG, n, s, e, int'(vals[i]));
      end
      print_verdict();
   end
endmodule
